// File: rtl/crate_detect_params.svh
`ifndef CRATE_DETECT_PARAMS_SVH
`define CRATE_DETECT_PARAMS_SVH
// Settling time of the presence pull-up before it is sampled, in ns
`define PRESENCE_SETTLE_NS 1000
// Clock period in ns
`define REF_CLK_PERIOD_NS 8
// Settling time as whole clock cycles, rounded up
`define PRESENCE_SETTLE_CYC ((`PRESENCE_SETTLE_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
// Width of the settle counter
`define SETTLE_CNT_W 8
// Number of sensor threshold inputs
`define SENSOR_NUM 4
`endif

// File: rtl/crate_detect_pkg.sv
`default_nettype none
package crate_detect_pkg;
    // Operating mode chosen at power-up
    typedef enum logic [1:0] {
        MODE_UNDECIDED,
        MODE_IN_CRATE,
        MODE_BENCH
    } op_mode_e;
    // Payload power state machine
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_ON
    } pwr_state_e;
endpackage : crate_detect_pkg
`default_nettype wire

// File: rtl/event_edge_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "crate_detect_params.svh"

// Emits a one-cycle event pulse on each rising edge of any input bit
module event_edge_gen #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] event_pulse
);
    // Previous level per bit
    logic [WIDTH-1:0] level_r;

    // Track previous level and form pulses per bit
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    level_r[gi] <= 1'b0;
                    event_pulse[gi] <= 1'b0;
                end else begin
                    level_r[gi] <= level[gi];
                    // Pulse only while management is active
                    event_pulse[gi] <= enable & level[gi] & ~level_r[gi];
                end
            end
        end
    endgenerate
endmodule : event_edge_gen
`default_nettype wire

// File: rtl/crate_detect_power_manager.sv
// Function
// - Sample presence pin before any management activity
// - Presence high selects out-of-crate bench mode
// - Presence low selects normal in-crate mode
// - In-crate, power follows hub commands
// - Bench mode powers payload without hub
// - Bench mode: handle closed powers, open unpowers
// - Rear module power follows payload power
// - Events on handle changes and sensor limits
`timescale 1ns/1ps
`default_nettype none
`include "crate_detect_params.svh"

module crate_detect_power_manager
    import crate_detect_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic board_presence_sense_n,      // Pulled-up presence pin
    input wire logic handle_closed,               // Hot-swap handle pin, 1 = closed
    input wire logic hub_power_on_cmd,            // Hub payload-on request (same clock)
    input wire logic hub_power_off_cmd,           // Hub payload-off request (same clock)
    input wire logic [`SENSOR_NUM-1:0] sensor_over_limit, // Threshold flags (same clock)
    output logic payload_power_en,
    output logic rear_power_en,
    output logic bench_mode,
    output logic mode_valid,
    output logic handle_insert_event,
    output logic handle_extract_event,
    output logic [`SENSOR_NUM-1:0] sensor_event
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic pres_meta_r;   // First stage, read only by second stage
    logic pres_sync_r;   // Synchronised presence
    logic hdl_meta_r;    // First stage of handle
    logic hdl_sync_r;    // Synchronised handle

    // Two-flop synchronisers for the presence and handle pins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pres_meta_r <= 1'b1;
            pres_sync_r <= 1'b1;
            hdl_meta_r <= 1'b0;
            hdl_sync_r <= 1'b0;
        end else begin
            pres_meta_r <= board_presence_sense_n;
            pres_sync_r <= pres_meta_r;
            hdl_meta_r <= handle_closed;
            hdl_sync_r <= hdl_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decision

    localparam logic [`SETTLE_CNT_W-1:0] SETTLE_LAST =
        `SETTLE_CNT_W'(`PRESENCE_SETTLE_CYC - 1);

    logic [`SETTLE_CNT_W-1:0] settle_cnt_r;  // Pull-up settle counter
    op_mode_e mode_r;                        // Latched mode

    // Wait for the pull-up to settle, then sample once and hold
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            settle_cnt_r <= '0;
            mode_r <= MODE_UNDECIDED;
        end else if (mode_r == MODE_UNDECIDED) begin
            if (settle_cnt_r == SETTLE_LAST) begin
                // Sample the presence level once
                if (pres_sync_r) begin
                    mode_r <= MODE_BENCH;
                end else begin
                    mode_r <= MODE_IN_CRATE;
                end
            end else begin
                settle_cnt_r <= settle_cnt_r + `SETTLE_CNT_W'(1);
            end
        end
        // Once decided, later presence changes are ignored until reset
    end

    assign mode_valid = (mode_r != MODE_UNDECIDED);
    assign bench_mode = (mode_r == MODE_BENCH);

    ////////////////////////////////////////////////////////////////////////////
    // Payload power control

    pwr_state_e pwr_r;  // Payload power state
    pwr_state_e pwr_nxt;

    // Next power state from hub commands or handle
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (mode_r)
            MODE_IN_CRATE: begin
                // Hub supervises power; off wins over on
                if (hub_power_off_cmd) begin
                    pwr_nxt = PWR_OFF;
                end else if (hub_power_on_cmd) begin
                    pwr_nxt = PWR_ON;
                end
            end
            MODE_BENCH: begin
                // Handle acts as power switch, hub ignored
                pwr_nxt = hdl_sync_r ? PWR_ON : PWR_OFF;
            end
            default: begin
                // No activity before the mode is known
                pwr_nxt = PWR_OFF;
            end
        endcase
    end

    // Power state register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_r <= PWR_OFF;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // Enables registered from the next power state
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            payload_power_en <= 1'b0;
            rear_power_en <= 1'b0;
        end else begin
            payload_power_en <= (pwr_nxt == PWR_ON);
            rear_power_en <= (pwr_nxt == PWR_ON);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System events

    logic [`SENSOR_NUM+1:0] ev_level;  // Event source levels
    logic [`SENSOR_NUM+1:0] ev_pulse;  // Rising-edge pulses

    // Edge memories reset low, so the inverted handle bit shows a false rise
    // after reset; the enable keeps it quiet until the mode is decided
    assign ev_level = {sensor_over_limit, ~hdl_sync_r, hdl_sync_r};

    // Edge detector for handle and sensor events
    event_edge_gen #(
        .WIDTH(`SENSOR_NUM + 2)
    ) u_events (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .enable(mode_valid),
        .level(ev_level),
        .event_pulse(ev_pulse)
    );

    assign handle_insert_event = ev_pulse[0];
    assign handle_extract_event = ev_pulse[1];
    assign sensor_event = ev_pulse[`SENSOR_NUM+1:2];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    // Bench mode with the handle closed
    sequence s_bench_closed;
        bench_mode && hdl_sync_r;
    endsequence

    // Handle closing seen after the synchroniser, mode decided
    sequence s_handle_rise;
        mode_valid && $rose(hdl_sync_r);
    endsequence

    // Handle opening seen after the synchroniser, mode decided
    sequence s_handle_fall;
        mode_valid && $fell(hdl_sync_r);
    endsequence

    // Mode decision: nothing powered early, mode taken from sampled level

    AST_NO_POWER_UNDECIDED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !mode_valid |-> !payload_power_en)
        else $error("Power on before mode decided");
    AST_BENCH_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!mode_valid ##1 mode_valid) |-> (bench_mode == $past(pres_sync_r)))
        else $error("Bench mode not from high presence");
    AST_CRATE_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ($rose(mode_valid) && !$past(pres_sync_r)) |-> mode_r == MODE_IN_CRATE)
        else $error("Crate mode not from low presence");
    // Power control: hub in crate, handle on the bench, rear follows payload
    AST_HUB_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode_r == MODE_IN_CRATE && hub_power_on_cmd && !hub_power_off_cmd)
        |=> payload_power_en)
        else $error("Hub on command ignored");
    AST_HUB_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode_r == MODE_IN_CRATE && hub_power_off_cmd) |=> !payload_power_en)
        else $error("Hub off command ignored");
    AST_BENCH_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_bench_closed |=> payload_power_en)
        else $error("Bench power not applied");
    AST_BENCH_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bench_mode && !hdl_sync_r) |=> !payload_power_en)
        else $error("Open handle did not remove power");
    AST_REAR_FOLLOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rear_power_en == payload_power_en)
        else $error("Rear power differs from payload");
    // Events: one pulse per handle or threshold edge, none before decision
    AST_INSERT_EVENT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_handle_rise |=> handle_insert_event)
        else $error("Missing insert event");
    AST_EXTRACT_EVENT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_handle_fall |=> handle_extract_event)
        else $error("Missing extract event");
    AST_SENSOR_EVENT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        mode_valid |=>
            (sensor_event == ($past(sensor_over_limit) & ~$past(sensor_over_limit, 2))))
        else $error("Sensor event does not match a threshold crossing");
    AST_NO_EVENT_UNDECIDED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !mode_valid |=> (!handle_insert_event && !handle_extract_event
            && (sensor_event == '0)))
        else $error("Event raised before mode decided");
    AST_MODE_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        mode_valid |=> (mode_valid && $stable(mode_r)))
        else $error("Mode changed after decision");

endmodule : crate_detect_power_manager
`default_nettype wire

// File: tb/hub_model.sv
`timescale 1ns/1ps
`default_nettype none

// Crate hub side: sends one-cycle power requests
module hub_model (
    input wire logic ref_clk,
    output logic hub_power_on_cmd,
    output logic hub_power_off_cmd
);
    // Idle hub sends nothing
    initial begin
        hub_power_on_cmd = 1'H0;
        hub_power_off_cmd = 1'H0;
    end

    // Request held across one rising edge, launched at the falling edge
    task send(input logic on_req, input logic off_req);
        @(negedge ref_clk);
        hub_power_on_cmd = on_req;
        hub_power_off_cmd = off_req;
        @(negedge ref_clk);
        hub_power_on_cmd = 1'H0;
        hub_power_off_cmd = 1'H0;
    endtask : send
endmodule : hub_model

`default_nettype wire

// File: tb/tb_crate_detect_power_manager.sv
`timescale 1ns/1ps
`default_nettype none

module tb_crate_detect_power_manager;
    import crate_detect_pkg::*;
    logic ref_clk = 1'H0; // 125 MHz
    logic sys_rst = 1'H1;
    logic board_presence_sense_n = 1'H1;
    logic handle_closed = 1'H0;
    logic [3:0] sensor_over_limit = 4'H0;
    wire logic on_cmd, off_cmd;
    logic pwr, rear, bench, valid, ins, ext;
    logic [3:0] sev;
    logic [3:0] sacc; // Sensors that pulsed
    integer ni, ne, nsx; // Pulse counts
    integer n_errors = 0;
    integer compares = 0;

    always #4 ref_clk = ~ref_clk;

    hub_model hub (.ref_clk(ref_clk), .hub_power_on_cmd(on_cmd), .hub_power_off_cmd(off_cmd));

    crate_detect_power_manager dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .board_presence_sense_n(board_presence_sense_n), .handle_closed(handle_closed),
        .hub_power_on_cmd(on_cmd), .hub_power_off_cmd(off_cmd),
        .sensor_over_limit(sensor_over_limit), .payload_power_en(pwr), .rear_power_en(rear),
        .bench_mode(bench), .mode_valid(valid), .handle_insert_event(ins),
        .handle_extract_event(ext), .sensor_event(sev));

    ////////////////////////////////////////////////////////////////////////
    // Event pulses are counted on every rising edge
    always @(posedge ref_clk) begin
        ni <= ni + ins;
        ne <= ne + ext;
        nsx <= nsx + $countones(sev);
        sacc <= sacc | sev;
    end

    // Bit comparison
    task chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk

    // Count comparison
    task chk_n(input integer got, input integer exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_n

    // Reset for 4 cycles with the given presence level
    task do_rst(input logic pres_n);
        sys_rst = 1'H1;
        board_presence_sense_n = pres_n;
        handle_closed = 1'H0;
        repeat (4) @(negedge ref_clk);
        ni = 0;
        ne = 0;
        nsx = 0;
        sacc = 4'H0;
        sys_rst = 1'H0;
    endtask : do_rst

    // Bounded wait for the mode decision
    task wait_mode;
        for (int i = 0; i < 300 && valid !== 1'H1; i++) @(negedge ref_clk);
        chk(valid, 1'H1);
    endtask : wait_mode

    ////////////////////////////////////////////////////////////////////////
    // In crate: hub drives power, handle only raises events
    task crate_test;
        do_rst(1'H0);
        repeat (98) @(negedge ref_clk);
        chk(valid, 1'H0);
        hub.send(1'H1, 1'H0);
        chk(pwr, 1'H0);
        wait_mode;
        chk(bench, 1'H0);
        hub.send(1'H1, 1'H1);
        repeat (2) @(negedge ref_clk);
        chk(pwr, 1'H0);
        handle_closed = 1'H1;
        repeat (6) @(negedge ref_clk);
        chk(pwr, 1'H0);
        chk_n(ni, 1);
        chk_n(ne, 0);
        hub.send(1'H1, 1'H0);
        repeat (2) @(negedge ref_clk);
        chk(pwr, 1'H1);
        chk(rear, 1'H1);
        board_presence_sense_n = 1'H1;
        repeat (10) @(negedge ref_clk);
        chk(bench, 1'H0);
        hub.send(1'H0, 1'H1);
        repeat (2) @(negedge ref_clk);
        chk(pwr, 1'H0);
    endtask : crate_test

    // Bench: handle is the power switch, hub ignored, sensors raise events
    task bench_test;
        do_rst(1'H1);
        wait_mode;
        chk(bench, 1'H1);
        hub.send(1'H1, 1'H0);
        repeat (3) @(negedge ref_clk);
        chk(pwr, 1'H0);
        handle_closed = 1'H1;
        repeat (6) @(negedge ref_clk);
        chk(pwr, 1'H1);
        chk(rear, 1'H1);
        chk_n(ni, 1);
        handle_closed = 1'H0;
        repeat (6) @(negedge ref_clk);
        chk(pwr, 1'H0);
        chk(rear, 1'H0);
        chk_n(ne, 1);
        sensor_over_limit = 4'H5;
        repeat (4) @(negedge ref_clk);
        sensor_over_limit = 4'HF;
        repeat (4) @(negedge ref_clk);
        chk_n(nsx, 4);
        chk(sacc === 4'HF, 1'H1);
    endtask : bench_test

    // Prints counts and verdict, then ends the run
    task stop_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // Watchdog well beyond the expected run
    initial begin
        #16000;
        n_errors++;
        stop_test;
    end

    // Main sequence
    initial begin
        crate_test;
        bench_test;
        stop_test;
    end
endmodule : tb_crate_detect_power_manager

`default_nettype wire
